// >>> pkg/pabm_pkg.sv
// constants, override types and pin resolution for the port a/b mux
package pabm_pkg;

  // ****************************************************************
  // widths and bit positions
  // ****************************************************************
  localparam int PA_W        = 8;
  localparam int PB_LSB      = 2;
  localparam int PB_MSB      = 7;
  localparam int PB_W        = 6;
  localparam int PB_TMR2_BIT  = 7;
  localparam int PB_TMR1B_BIT = 6;
  localparam int PB_TMR1A_BIT = 5;
  localparam int PB_TMR0_BIT  = 4;
  localparam int PB_MISO_BIT = 3;
  localparam int PB_MOSI_BIT = 2;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic RST_OE_N = 1'b1;  // driver off
  localparam logic RST_LVL  = 1'b0;

  // ****************************************************************
  // override bundle and resolved pad controls
  // ****************************************************************
  typedef struct packed {
    logic pullup_ovr_en;
    logic pullup_ovr_val;
    logic dir_ovr_en;
    logic dir_ovr_val;
    logic value_ovr_en;
    logic value_ovr_val;
  } pabm_ovr_t;

  typedef struct packed {
    logic oe;
    logic val;
    logic pu;
  } pabm_pin_t;

  localparam pabm_ovr_t OVR_NONE = '0;

  // merges register bits with alternate function overrides
  function automatic pabm_pin_t pabm_resolve(input logic      dd,
                                             input logic      port,
                                             input logic      global_pullup_disable,
                                             input pabm_ovr_t ovr);
    pabm_pin_t p;
    p.oe  = ovr.dir_ovr_en ? ovr.dir_ovr_val : dd;
    p.val = ovr.value_ovr_en ? ovr.value_ovr_val : port;
    p.pu  = ovr.pullup_ovr_en ? ovr.pullup_ovr_val : (~dd & port & ~global_pullup_disable);
    return p;
  endfunction : pabm_resolve

endpackage : pabm_pkg

// >>> src/pabm_sync.sv
// three stage pad input synchroniser with agreement filter
`timescale 1ns/1ps
module pabm_sync
  import pabm_pkg::*;
#(
  parameter int W = PA_W
) (
  input  wire logic         ref_clk_i,
  input  wire logic         nrst_i,
  input  wire logic [W-1:0] pad_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] out_r;

  // synchroniser chain, first stage feeds only the second
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= pad_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // take a bit only once stages two and three agree
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      out_r <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          out_r[i] <= s3_r[i];
        end
      end
    end
  end

  assign sync_o = out_r;

endmodule : pabm_sync

// >>> src/pabm_mux.sv
// port a/b alternate function override mux with registered pad controls
//
// Functional notes
// - port a pin n carries address low bit n and data bit n.
// - port a pull-up, direction, value override enables equal memory enable.
// - port a drives during write or address phase; input feeds data in.
// - port a pull-up only when idle, gated by latch and pull-up disable.
// - bit 7 may carry timer1 compare c; needs direction output.
// - bit 6 carries timer1 compare b when direction is output.
// - bit 5 carries timer1 compare a when direction is output.
// - bit 4 carries timer0 compare when direction is output.
// - compare pins on bits 7..4 also carry pwm waveforms.
// - spi master forces bit 3 to input.
// - spi slave lets bit 3 direction follow its direction bit.
// - spi slave forces bit 2 to input.
// - spi master lets bit 2 direction follow its direction bit.
// - forced spi inputs keep pull-up controlled by the output latch.
// - legacy mode never offers timer1 compare c on bit 7.
// - direction override enable makes override value switch the driver.
// - value override enable makes override value the pin level.
`timescale 1ns/1ps
module pabm_mux
  import pabm_pkg::*;
(
  input  wire logic                ref_clk_i,
  input  wire logic                nrst_i,
  input  wire logic                global_pullup_disable_i,
  input  wire logic                sleep_clamp_i,
  input  wire logic                legacy_compat_i,
  input  wire logic                ext_mem_enable_i,
  input  wire logic                address_phase_active_i,
  input  wire logic                ext_wr_strobe_i,
  input  wire logic [PA_W-1:0]     addr_data_bit_i,
  input  wire logic [PA_W-1:0]     ext_data_out_i,
  input  wire logic [PA_W-1:0]     porta_out_latch_bit_i,
  input  wire logic [PA_W-1:0]     porta_dir_i,
  input  wire logic [PA_W-1:0]     porta_pad_in_i,
  input  wire logic [PB_MSB:PB_LSB] portb_dir_i,
  input  wire logic [PB_MSB:PB_LSB] portb_out_latch_i,
  input  wire logic [PB_MSB:PB_LSB] portb_pad_in_i,
  input  wire logic                timer2_compare_out_i,
  input  wire logic                timer2_compare_en_i,
  input  wire logic                timer1_compare_c_out_i,
  input  wire logic                timer1_compare_c_en_i,
  input  wire logic                timer1_compare_b_out_i,
  input  wire logic                timer1_compare_b_en_i,
  input  wire logic                timer1_compare_a_out_i,
  input  wire logic                timer1_compare_a_en_i,
  input  wire logic                timer0_compare_out_i,
  input  wire logic                timer0_compare_en_i,
  input  wire logic                spi_enable_i,
  input  wire logic                spi_master_i,
  input  wire logic                spi_master_out_i,
  input  wire logic                spi_slave_out_i,
  output logic      [PA_W-1:0]     porta_pad_out_o,
  output logic      [PA_W-1:0]     porta_pad_oe_n_o,
  output logic      [PA_W-1:0]     porta_pullup_en_o,
  output logic                     porta_in_en_o,
  output logic      [PA_W-1:0]     porta_pin_o,
  output logic      [PA_W-1:0]     ext_data_in_o,
  output logic      [PB_MSB:PB_LSB] portb_pad_out_o,
  output logic      [PB_MSB:PB_LSB] portb_pad_oe_n_o,
  output logic      [PB_MSB:PB_LSB] portb_pullup_en_o,
  output logic                     portb_in_en_o,
  output logic      [PB_MSB:PB_LSB] portb_pin_o,
  output logic                     spi_master_in_o,
  output logic                     spi_slave_in_o
);

  // ****************************************************************
  // override generation
  // ****************************************************************
  pabm_ovr_t        pa_ovr  [PA_W];
  pabm_ovr_t        pb_ovr  [PB_MSB:PB_LSB];
  pabm_pin_t        pa_pin  [PA_W];
  pabm_pin_t        pb_pin  [PB_MSB:PB_LSB];
  logic             bus_busy;
  logic             spi_mst;
  logic             spi_slv;
  logic             tmr1c_ok;
  logic [PA_W-1:0]  pa_sync;
  logic [PB_W-1:0]  pb_sync;
  logic [PA_W-1:0]  pa_out_r;
  logic [PA_W-1:0]  pa_oe_n_r;
  logic [PA_W-1:0]  pa_pu_r;
  logic [PB_MSB:PB_LSB] pb_out_r;
  logic [PB_MSB:PB_LSB] pb_oe_n_r;
  logic [PB_MSB:PB_LSB] pb_pu_r;
  logic             in_en_r;

  assign bus_busy = ext_wr_strobe_i | address_phase_active_i;
  assign spi_mst  = spi_enable_i & spi_master_i;
  assign spi_slv  = spi_enable_i & ~spi_master_i;
  assign tmr1c_ok = timer1_compare_c_en_i & ~legacy_compat_i;

  // port a overrides, all enables follow memory enable
  generate
    for (genvar n = 0; n < PA_W; n++) begin : g_pa
      always_comb begin
        pa_ovr[n].pullup_ovr_en = ext_mem_enable_i;
        pa_ovr[n].dir_ovr_en    = ext_mem_enable_i;
        pa_ovr[n].value_ovr_en  = ext_mem_enable_i;
        pa_ovr[n].dir_ovr_val   = bus_busy;
        pa_ovr[n].pullup_ovr_val = ~bus_busy & porta_out_latch_bit_i[n]
                                   & ~global_pullup_disable_i;
        pa_ovr[n].value_ovr_val =
          (addr_data_bit_i[n] & address_phase_active_i)
          | (ext_data_out_i[n] & ext_wr_strobe_i);
      end
      assign pa_pin[n] = pabm_resolve(porta_dir_i[n],
                                      porta_out_latch_bit_i[n],
                                      global_pullup_disable_i,
                                      pa_ovr[n]);
    end
  endgenerate

  // port b overrides, timers drive value only, spi steers direction
  always_comb begin
    for (int i = PB_LSB; i <= PB_MSB; i++) begin
      pb_ovr[i] = OVR_NONE;
    end
    // both compare sources on bit 7: latch low ands them, high ors them
    pb_ovr[PB_TMR2_BIT].value_ovr_en = timer2_compare_en_i
                                       | tmr1c_ok;
    if (timer2_compare_en_i && tmr1c_ok) begin
      pb_ovr[PB_TMR2_BIT].value_ovr_val = portb_out_latch_i[PB_TMR2_BIT]
        ? (timer2_compare_out_i | timer1_compare_c_out_i)
        : (timer2_compare_out_i & timer1_compare_c_out_i);
    end else begin
      pb_ovr[PB_TMR2_BIT].value_ovr_val = timer2_compare_en_i
        ? timer2_compare_out_i : timer1_compare_c_out_i;
    end
    pb_ovr[PB_TMR1B_BIT].value_ovr_en  = timer1_compare_b_en_i;
    pb_ovr[PB_TMR1B_BIT].value_ovr_val = timer1_compare_b_out_i;
    pb_ovr[PB_TMR1A_BIT].value_ovr_en  = timer1_compare_a_en_i;
    pb_ovr[PB_TMR1A_BIT].value_ovr_val = timer1_compare_a_out_i;
    pb_ovr[PB_TMR0_BIT].value_ovr_en   = timer0_compare_en_i;
    pb_ovr[PB_TMR0_BIT].value_ovr_val  = timer0_compare_out_i;
    // data-in pin: master forces input, slave drives its output
    pb_ovr[PB_MISO_BIT].dir_ovr_en = spi_mst;
    pb_ovr[PB_MISO_BIT].pullup_ovr_en = spi_mst;
    pb_ovr[PB_MISO_BIT].pullup_ovr_val = portb_out_latch_i[PB_MISO_BIT]
                                 & ~global_pullup_disable_i;
    pb_ovr[PB_MISO_BIT].value_ovr_en = spi_slv;
    pb_ovr[PB_MISO_BIT].value_ovr_val = spi_slave_out_i;
    // data-out pin: slave forces input, master drives its output
    pb_ovr[PB_MOSI_BIT].dir_ovr_en = spi_slv;
    pb_ovr[PB_MOSI_BIT].pullup_ovr_en = spi_slv;
    pb_ovr[PB_MOSI_BIT].pullup_ovr_val = portb_out_latch_i[PB_MOSI_BIT]
                                 & ~global_pullup_disable_i;
    pb_ovr[PB_MOSI_BIT].value_ovr_en = spi_mst;
    pb_ovr[PB_MOSI_BIT].value_ovr_val = spi_master_out_i;
  end

  generate
    for (genvar m = PB_LSB; m <= PB_MSB; m++) begin : g_pb
      assign pb_pin[m] = pabm_resolve(portb_dir_i[m],
                                      portb_out_latch_i[m],
                                      global_pullup_disable_i,
                                      pb_ovr[m]);
    end
  endgenerate

  // ****************************************************************
  // pad control registers
  // ****************************************************************
  // port a pad drive, value and pull-up
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pa_out_r  <= {PA_W{RST_LVL}};
      pa_oe_n_r <= {PA_W{RST_OE_N}};
      pa_pu_r   <= {PA_W{RST_LVL}};
    end else begin
      for (int i = 0; i < PA_W; i++) begin
        pa_out_r[i]  <= pa_pin[i].val;
        pa_oe_n_r[i] <= ~pa_pin[i].oe;
        pa_pu_r[i]   <= pa_pin[i].pu;
      end
    end
  end

  // port b pad drive, value and pull-up
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pb_out_r  <= {PB_W{RST_LVL}};
      pb_oe_n_r <= {PB_W{RST_OE_N}};
      pb_pu_r   <= {PB_W{RST_LVL}};
    end else begin
      for (int i = PB_LSB; i <= PB_MSB; i++) begin
        pb_out_r[i]  <= pb_pin[i].val;
        pb_oe_n_r[i] <= ~pb_pin[i].oe;
        pb_pu_r[i]   <= pb_pin[i].pu;
      end
    end
  end

  // input enable follows sleep clamp, no pin overrides it here
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      in_en_r <= RST_LVL;
    end else begin
      in_en_r <= ~sleep_clamp_i;
    end
  end

  // ****************************************************************
  // pad input synchronisers
  // ****************************************************************
  pabm_sync #(.W(PA_W)) u_sync_pa (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .pad_i     (porta_pad_in_i),
    .sync_o    (pa_sync)
  );

  pabm_sync #(.W(PB_W)) u_sync_pb (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .pad_i     (portb_pad_in_i),
    .sync_o    (pb_sync)
  );

  // outputs, all taken from flip-flops
  assign porta_pad_out_o   = pa_out_r;
  assign porta_pad_oe_n_o  = pa_oe_n_r;
  assign porta_pullup_en_o = pa_pu_r;
  assign porta_in_en_o     = in_en_r;
  assign porta_pin_o       = pa_sync;
  assign ext_data_in_o     = pa_sync;
  assign portb_pad_out_o   = pb_out_r;
  assign portb_pad_oe_n_o  = pb_oe_n_r;
  assign portb_pullup_en_o = pb_pu_r;
  assign portb_in_en_o     = in_en_r;
  assign portb_pin_o       = pb_sync;
  assign spi_master_in_o   = pb_sync[PB_MISO_BIT-PB_LSB];
  assign spi_slave_in_o    = pb_sync[PB_MOSI_BIT-PB_LSB];

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  sequence s_addr_phase;
    ext_mem_enable_i && address_phase_active_i && !ext_wr_strobe_i;
  endsequence

  sequence s_write_phase;
    ext_mem_enable_i && ext_wr_strobe_i && !address_phase_active_i;
  endsequence

  sequence s_pa_steady;
    $stable(porta_pad_in_i) [*5];
  endsequence

  a_pa_addr_out: assert property (
    s_addr_phase |=> porta_pad_oe_n_o == '0
                     && porta_pad_out_o == $past(addr_data_bit_i))
    else $error("port a address not driven");
  a_pa_write_out: assert property (
    s_write_phase |=> porta_pad_oe_n_o == '0
                      && porta_pad_out_o == $past(ext_data_out_i))
    else $error("port a write data not driven");
  a_pa_busy_pullup: assert property (
    ext_mem_enable_i && bus_busy |=> porta_pullup_en_o == '0)
    else $error("port a pull-up on while bus busy");
  a_pa_released: assert property (
    !ext_mem_enable_i |=> porta_pad_oe_n_o == ~$past(porta_dir_i)
                          && porta_pad_out_o == $past(porta_out_latch_bit_i))
    else $error("port a not under register control");
  a_pa_in_path: assert property (
    s_pa_steady |-> ext_data_in_o == porta_pad_in_i)
    else $error("port a input not delivered");
  a_pb_timer_dir: assert property (
    1'b1 |=> portb_pad_oe_n_o[PB_MSB:PB_TMR0_BIT]
             == ~$past(portb_dir_i[PB_MSB:PB_TMR0_BIT]))
    else $error("timer pin direction not from register");
  a_pb_tmr1a_val: assert property (
    timer1_compare_a_en_i |=> portb_pad_out_o[PB_TMR1A_BIT]
                              == $past(timer1_compare_a_out_i))
    else $error("compare a not on pin");
  a_pb7_legacy: assert property (
    legacy_compat_i && !timer2_compare_en_i |=>
      portb_pad_out_o[PB_TMR2_BIT] == $past(portb_out_latch_i[PB_TMR2_BIT]))
    else $error("compare c offered in legacy mode");
  a_pb_miso_in: assert property (
    spi_mst |=> portb_pad_oe_n_o[PB_MISO_BIT]
                && portb_pullup_en_o[PB_MISO_BIT]
                   == $past(portb_out_latch_i[PB_MISO_BIT]
                            & ~global_pullup_disable_i))
    else $error("data-in pin not forced to input");
  a_pb_mosi_in: assert property (
    spi_slv |=> portb_pad_oe_n_o[PB_MOSI_BIT]
                && portb_pad_oe_n_o[PB_MISO_BIT]
                   == !$past(portb_dir_i[PB_MISO_BIT]))
    else $error("slave pin directions wrong");

endmodule : pabm_mux

// >>> test/pabm_far_model.sv
// far side pad model: memory chip, spi peer and pin wiring
`timescale 1ns/1ps
module pabm_far_model
  import pabm_pkg::*;
(
  input  wire logic                 ref_clk_i,
  input  wire logic [PA_W-1:0]      pa_out_i,
  input  wire logic [PA_W-1:0]      pa_oe_n_i,
  input  wire logic [PA_W-1:0]      pa_pu_i,
  input  wire logic [PB_MSB:PB_LSB] pb_out_i,
  input  wire logic [PB_MSB:PB_LSB] pb_oe_n_i,
  input  wire logic [PB_MSB:PB_LSB] pb_pu_i,
  input  wire logic                 mem_drive_i,
  input  wire logic [PA_W-1:0]      mem_data_i,
  input  wire logic [PB_MSB:PB_LSB] peer_drive_i,
  input  wire logic [PB_MSB:PB_LSB] peer_data_i,
  output logic      [PA_W-1:0]      pa_level_o,
  output logic      [PB_MSB:PB_LSB] pb_level_o
);
  logic float_r;

  // undriven pins without pull-up wander every cycle
  initial float_r = 1'b0;
  always @(posedge ref_clk_i) float_r <= ~float_r;

  // ****************************************************************
  // pad level resolution: device driver, far driver, pull-up, float
  // ****************************************************************
  always_comb begin
    for (int i = 0; i < PA_W; i++) begin
      if (!pa_oe_n_i[i]) pa_level_o[i] = pa_out_i[i];
      else if (mem_drive_i) pa_level_o[i] = mem_data_i[i]; // read data
      else if (pa_pu_i[i]) pa_level_o[i] = 1'b1;
      else pa_level_o[i] = float_r ^ i[0];
    end
    for (int j = PB_LSB; j <= PB_MSB; j++) begin
      if (!pb_oe_n_i[j]) pb_level_o[j] = pb_out_i[j];
      else if (peer_drive_i[j]) pb_level_o[j] = peer_data_i[j];
      else if (pb_pu_i[j]) pb_level_o[j] = 1'b1;
      else pb_level_o[j] = float_r ^ j[0];
    end
  end
endmodule : pabm_far_model

// >>> test/pabm_mux_test.sv
// self-checking bench for the port a/b alternate function mux
`timescale 1ns/1ps
module pabm_mux_test
  import pabm_pkg::*;
;
  logic ref_clk_i, nrst_i, global_pullup_disable_i, sleep_clamp_i;
  logic legacy_compat_i, ext_mem_enable_i, address_phase_active_i;
  logic ext_wr_strobe_i, timer2_compare_out_i, timer2_compare_en_i;
  logic timer1_compare_c_out_i, timer1_compare_c_en_i;
  logic timer1_compare_b_out_i, timer1_compare_b_en_i;
  logic timer1_compare_a_out_i, timer1_compare_a_en_i;
  logic timer0_compare_out_i, timer0_compare_en_i, spi_enable_i;
  logic spi_master_i, spi_master_out_i, spi_slave_out_i, mem_drive;
  logic porta_in_en_o, portb_in_en_o, spi_master_in_o, spi_slave_in_o;
  logic [PA_W-1:0] addr_data_bit_i, ext_data_out_i, porta_out_latch_bit_i;
  logic [PA_W-1:0] porta_dir_i, porta_pad_in_i, mem_data, porta_pad_out_o;
  logic [PA_W-1:0] porta_pad_oe_n_o, porta_pullup_en_o, porta_pin_o;
  logic [PA_W-1:0] ext_data_in_o;
  logic [PB_MSB:PB_LSB] portb_dir_i, portb_out_latch_i, portb_pad_in_i;
  logic [PB_MSB:PB_LSB] peer_drive, peer_data, portb_pad_out_o;
  logic [PB_MSB:PB_LSB] portb_pad_oe_n_o, portb_pullup_en_o, portb_pin_o;
  int fail_count, checked, cycles;

  pabm_mux DUT (.ref_clk_i, .nrst_i, .global_pullup_disable_i,
    .sleep_clamp_i, .legacy_compat_i, .ext_mem_enable_i,
    .address_phase_active_i, .ext_wr_strobe_i, .addr_data_bit_i,
    .ext_data_out_i, .porta_out_latch_bit_i, .porta_dir_i, .porta_pad_in_i,
    .portb_dir_i, .portb_out_latch_i, .portb_pad_in_i,
    .timer2_compare_out_i, .timer2_compare_en_i, .timer1_compare_c_out_i,
    .timer1_compare_c_en_i, .timer1_compare_b_out_i, .timer1_compare_b_en_i,
    .timer1_compare_a_out_i, .timer1_compare_a_en_i, .timer0_compare_out_i,
    .timer0_compare_en_i, .spi_enable_i, .spi_master_i, .spi_master_out_i,
    .spi_slave_out_i, .porta_pad_out_o, .porta_pad_oe_n_o,
    .porta_pullup_en_o, .porta_in_en_o, .porta_pin_o, .ext_data_in_o,
    .portb_pad_out_o, .portb_pad_oe_n_o, .portb_pullup_en_o, .portb_in_en_o,
    .portb_pin_o, .spi_master_in_o, .spi_slave_in_o);

  pabm_far_model far (.ref_clk_i(ref_clk_i), .pa_out_i(porta_pad_out_o),
    .pa_oe_n_i(porta_pad_oe_n_o), .pa_pu_i(porta_pullup_en_o),
    .pb_out_i(portb_pad_out_o), .pb_oe_n_i(portb_pad_oe_n_o),
    .pb_pu_i(portb_pullup_en_o), .mem_drive_i(mem_drive),
    .mem_data_i(mem_data), .peer_drive_i(peer_drive),
    .peer_data_i(peer_data), .pa_level_o(porta_pad_in_i),
    .pb_level_o(portb_pad_in_i));

  // ****************************************************************
  // clock, timeout and shared tasks
  // ****************************************************************
  initial ref_clk_i = 1'b0;
  always #2.5 ref_clk_i = ~ref_clk_i;

  // a hung run counts as a mismatch
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 1000) begin
      fail_count++;
      print_verdict();
    end
  end

  task automatic step(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask : step

  task automatic check(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {nrst_i, global_pullup_disable_i, sleep_clamp_i, legacy_compat_i} = '0;
    {ext_mem_enable_i, address_phase_active_i, ext_wr_strobe_i} = '0;
    {timer2_compare_out_i, timer2_compare_en_i, timer1_compare_c_out_i} = '0;
    {timer1_compare_c_en_i, timer1_compare_b_out_i} = '0;
    {timer1_compare_b_en_i, timer1_compare_a_out_i} = '0;
    {timer1_compare_a_en_i, timer0_compare_out_i, timer0_compare_en_i} = '0;
    {spi_enable_i, spi_master_i, spi_master_out_i, spi_slave_out_i} = '0;
    {addr_data_bit_i, ext_data_out_i, porta_out_latch_bit_i} = '0;
    {porta_dir_i, portb_dir_i, portb_out_latch_i, mem_drive} = '0;
    {mem_data, peer_drive, peer_data} = '0;
    step(3);
    nrst_i = 1'b1;
    // memory address phase then write phase
    {ext_mem_enable_i, address_phase_active_i} = 2'h3;
    addr_data_bit_i = 8'h5A;
    porta_out_latch_bit_i = 8'hFF;
    step(1);
    check("pa_oe_n", porta_pad_oe_n_o, 8'h00);
    check("pa_addr", porta_pad_out_o, 8'h5A);
    check("pa_pu", porta_pullup_en_o, 8'h00);
    {address_phase_active_i, ext_wr_strobe_i} = 2'h1;
    ext_data_out_i = 8'hC3;
    step(1);
    check("pa_wr_oe_n", porta_pad_oe_n_o, 8'h00);
    check("pa_data", porta_pad_out_o, 8'hC3);
    // idle bus ignores direction bits, pull-up follows latch
    ext_wr_strobe_i = 1'b0;
    porta_out_latch_bit_i = 8'h96;
    porta_dir_i = 8'hFF;
    step(1);
    check("pa_idle_oe_n", porta_pad_oe_n_o, 8'hFF);
    check("pa_idle_out", porta_pad_out_o, 8'h00);
    check("pa_idle_pu", porta_pullup_en_o, 8'h96);
    global_pullup_disable_i = 1'b1;
    step(1);
    check("pa_pu_off", porta_pullup_en_o, 8'h00);
    // memory read: chip drives the bus
    mem_data = 8'hA5;
    mem_drive = 1'b1;
    step(5);
    check("ext_rd", ext_data_in_o, 8'hA5);
    check("pa_pin", porta_pin_o, 8'hA5);
    mem_drive = 1'b0;
    global_pullup_disable_i = 1'b0;
    // memory off: port a back to register control
    ext_mem_enable_i = 1'b0;
    porta_dir_i = 8'h0F;
    porta_out_latch_bit_i = 8'h33;
    step(1);
    check("pa_reg_oe_n", porta_pad_oe_n_o, 8'hF0);
    check("pa_reg_out", porta_pad_out_o, 8'h33);
    check("pa_reg_pu", porta_pullup_en_o, 8'h30);
    // timer compare and pwm waveforms on bits 7..4
    portb_dir_i = 6'h3F;
    {timer2_compare_en_i, timer1_compare_b_en_i} = 2'h3;
    {timer1_compare_a_en_i, timer0_compare_en_i} = 2'h3;
    for (int p = 0; p < 2; p++) begin
      {timer2_compare_out_i, timer1_compare_b_out_i, timer1_compare_a_out_i,
       timer0_compare_out_i} = p[0] ? 4'h5 : 4'hA;
      step(1);
      check("pb_wave", {4'h0, portb_pad_out_o[7:4]},
            p[0] ? 8'h05 : 8'h0A);
    end
    portb_dir_i = 6'h1B;
    step(1);
    check("pb_tmr_oe_n", {4'h0, portb_pad_oe_n_o[7:4]}, 8'h09);
    // timer1 channel c alone on bit 7, then legacy mode hides it
    portb_dir_i = 6'h3F;
    timer2_compare_en_i = 1'b0;
    {timer1_compare_c_en_i, timer1_compare_c_out_i} = 2'h3;
    step(1);
    check("pb7_c", {7'h00, portb_pad_out_o[7]}, 8'h01);
    legacy_compat_i = 1'b1;
    step(1);
    check("pb7_legacy", {7'h00, portb_pad_out_o[7]}, 8'h00);
    // spi master: bit 3 forced input, bit 2 drives master data
    {spi_enable_i, spi_master_i, spi_master_out_i} = 3'h7;
    portb_out_latch_i = 6'h03;
    peer_drive = 6'h02;
    peer_data = 6'h02; // peer drives a high on bit 3
    step(1);
    check("mst_b3_oe_n", {7'h00, portb_pad_oe_n_o[3]}, 8'h01);
    check("mst_b3_pu", {7'h00, portb_pullup_en_o[3]}, 8'h01);
    check("mst_b2_oe_n", {7'h00, portb_pad_oe_n_o[2]}, 8'h00);
    check("mst_b2_out", {7'h00, portb_pad_out_o[2]}, 8'h01);
    step(4);
    check("mst_in", {7'h00, spi_master_in_o}, 8'h01);
    global_pullup_disable_i = 1'b1;
    step(1);
    check("mst_b3_pu_off", {7'h00, portb_pullup_en_o[3]}, 8'h00);
    // spi slave: bit 2 forced input, bit 3 follows its direction bit
    global_pullup_disable_i = 1'b0;
    {spi_master_i, spi_slave_out_i} = 2'h1;
    peer_drive = 6'h01;
    step(1);
    check("slv_b2_oe_n", {7'h00, portb_pad_oe_n_o[2]}, 8'h01);
    check("slv_b2_pu", {7'h00, portb_pullup_en_o[2]}, 8'h01);
    check("slv_b3_out", {7'h00, portb_pad_out_o[3]}, 8'h01);
    step(4);
    check("slv_in", {7'h00, spi_slave_in_o}, 8'h00);
    check("pb_pin", {6'h00, portb_pin_o[3:2]}, 8'h02);
    portb_dir_i = 6'h3D;
    step(1);
    check("slv_b3_oe_n", {7'h00, portb_pad_oe_n_o[3]}, 8'h01);
    // input enables on when awake, off once sleep clamps them
    check("in_en", {6'h00, porta_in_en_o, portb_in_en_o}, 8'h03);
    sleep_clamp_i = 1'b1;
    step(1);
    check("in_en_slp", {6'h00, porta_in_en_o, portb_in_en_o}, 8'h00);
    print_verdict();
  end
endmodule : pabm_mux_test
